/* File: wrc_regs.vh */
// Constants for the wake rate configuration block: offsets, fields, resets.
// Assumes the includer uses 8-bit register offsets and 8-bit data.
`ifndef WRC_REGS_VH
`define WRC_REGS_VH

// ============================================================
// Register offsets
`define WRC_OFS_RATE        8'h11
`define WRC_OFS_PWR         8'h1C
`define WRC_OFS_WINDOW      8'h29

// ============================================================
// Reset values
`define WRC_RST_RATE        8'h00
`define WRC_RST_PWR         8'h00
`define WRC_RST_WINDOW      8'h00
`define WRC_RST_HIDDEN      8'h00

// ============================================================
// Field positions of the rate select register and the power register
`define WRC_CODE_MSB        3
`define WRC_CODE_LSB        0
`define WRC_SEL_MSB         6
`define WRC_SEL_LSB         4
`define WRC_PWR_MSB         2
`define WRC_PWR_LSB         0

// ============================================================
// Power mode encodings of the low power-mode field
`define WRC_PM_ULP          3'h3
`define WRC_PM_LP           3'h0
`define WRC_PM_PREC         3'h4

// ============================================================
// Shadow selector codes
`define WRC_SEL_OFF         3'h0
`define WRC_SEL_BIAS        3'h1
`define WRC_SEL_SFPICK      3'h2
`define WRC_SEL_AFPICK      3'h3
`define WRC_SEL_SDIV_LO     3'h4
`define WRC_SEL_SDIV_HI     3'h5
`define WRC_SEL_ADIV_LO     3'h6
`define WRC_SEL_ADIV_HI     3'h7

// ============================================================
// Rate code of the software-defined rate
`define WRC_CODE_SOFT       4'hF

`endif

/* File: wrc_top.v */
// Wake rate configuration register bank with shadow tuning registers.
// Assumes a single-cycle register port: read data appear one cycle after
// the read strobe, and strobes never overlap.
`timescale 1ns/1ps
`include "wrc_regs.vh"

module wrc_top (
    // Clock and reset
    input  wire        i_core_clk,
    input  wire        i_rst_b,
    // Register port
    input  wire [7:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    // Effective wake rate
    output reg  [10:0] o_wake_rate_hz,
    output reg         o_rate_valid,
    output reg         o_soft_rate,
    output reg         o_manual_mode,
    // Shadow tuning values
    output reg  [3:0]  o_activity_bias_nibble,
    output reg  [3:0]  o_sampling_bias_nibble,
    output reg  [4:0]  o_sampling_freq_pick,
    output reg  [4:0]  o_activity_freq_pick,
    output reg  [15:0] o_sampling_clk_div,
    output reg  [15:0] o_activity_clk_div,
    // Ordinary window value when manual mode is off
    output reg  [7:0]  o_window_value
);

    // ============================================================
    // Rate table lookup: returns {valid, rate in Hz}.
    // Undefined codes return invalid and zero so downstream logic can hold
    // its previous rate instead of running at a random one.
    function [11:0] rate_lookup;
        input [2:0] pm;
        input [3:0] code;
        begin
            rate_lookup = 12'h000;
            case (pm)
                `WRC_PM_ULP: begin
                    case (code)
                        4'h6: rate_lookup = {1'b1, 11'd25};
                        4'h7: rate_lookup = {1'b1, 11'd50};
                        4'h8: rate_lookup = {1'b1, 11'd100};
                        4'h9: rate_lookup = {1'b1, 11'd190};
                        4'hA: rate_lookup = {1'b1, 11'd380};
                        4'hB: rate_lookup = {1'b1, 11'd750};
                        4'hC: rate_lookup = {1'b1, 11'd1100};
                        4'hF: rate_lookup = {1'b1, 11'd1300};
                        default: rate_lookup = 12'h000;
                    endcase
                end
                `WRC_PM_LP: begin
                    case (code)
                        4'h5: rate_lookup = {1'b1, 11'd14};
                        4'h6: rate_lookup = {1'b1, 11'd28};
                        4'h7: rate_lookup = {1'b1, 11'd54};
                        4'h8: rate_lookup = {1'b1, 11'd105};
                        4'h9: rate_lookup = {1'b1, 11'd210};
                        4'hA: rate_lookup = {1'b1, 11'd400};
                        4'hB: rate_lookup = {1'b1, 11'd600};
                        4'hF: rate_lookup = {1'b1, 11'd750};
                        default: rate_lookup = 12'h000;
                    endcase
                end
                `WRC_PM_PREC: begin
                    case (code)
                        4'h5: rate_lookup = {1'b1, 11'd14};
                        4'h6: rate_lookup = {1'b1, 11'd28};
                        4'h7: rate_lookup = {1'b1, 11'd55};
                        4'h8: rate_lookup = {1'b1, 11'd80};
                        4'hF: rate_lookup = {1'b1, 11'd100};
                        default: rate_lookup = 12'h000;
                    endcase
                end
                default: rate_lookup = 12'h000;
            endcase
        end
    endfunction

    // ============================================================
    // Register state
    reg  [6:0]  rate_reg;
    reg  [7:0]  pwr_reg;
    reg  [7:0]  window_reg;
    reg  [7:0]  shadow_reg [1:7];
    wire [2:0]  shadow_select;
    wire [3:0]  rate_code;
    wire [2:0]  pwr_mode;
    wire        wr_rate;
    wire        wr_pwr;
    wire        wr_win;
    wire [11:0] rate_next;
    reg  [7:0]  rdata_next;
    integer     k;

    assign shadow_select = rate_reg[`WRC_SEL_MSB:`WRC_SEL_LSB];
    assign rate_code     = rate_reg[`WRC_CODE_MSB:`WRC_CODE_LSB];
    assign pwr_mode      = pwr_reg[`WRC_PWR_MSB:`WRC_PWR_LSB];
    assign wr_rate       = i_wr && (i_addr == `WRC_OFS_RATE);
    assign wr_pwr        = i_wr && (i_addr == `WRC_OFS_PWR);
    assign wr_win        = i_wr && (i_addr == `WRC_OFS_WINDOW);
    assign rate_next     = rate_lookup(pwr_mode, rate_code);

    // ============================================================
    // Register writes
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rate_reg   <= 7'h00;
            pwr_reg    <= `WRC_RST_PWR;
            window_reg <= `WRC_RST_WINDOW;
            for (k = 1; k <= 7; k = k + 1) begin
                shadow_reg[k] <= `WRC_RST_HIDDEN;
            end
        end else begin
            if (wr_rate) begin
                rate_reg <= i_wdata[6:0];
            end
            if (wr_pwr) begin
                pwr_reg <= i_wdata;
            end
            if (wr_win) begin
                if (shadow_select == `WRC_SEL_OFF) begin
                    window_reg <= i_wdata;
                end else begin
                    shadow_reg[shadow_select] <= i_wdata;
                end
            end
        end
    end

    // ============================================================
    // Read mux; unmapped offsets read as zero.
    always @* begin
        rdata_next = 8'h00;
        case (i_addr)
            `WRC_OFS_RATE:   rdata_next = {1'b0, rate_reg};
            `WRC_OFS_PWR:    rdata_next = pwr_reg;
            `WRC_OFS_WINDOW: begin
                if (shadow_select == `WRC_SEL_OFF) begin
                    rdata_next = window_reg;
                end else if (shadow_select == `WRC_SEL_SFPICK ||
                             shadow_select == `WRC_SEL_AFPICK) begin
                    rdata_next = {3'h0, shadow_reg[shadow_select][4:0]};
                end else begin
                    rdata_next = shadow_reg[shadow_select];
                end
            end
            default: rdata_next = 8'h00;
        endcase
    end

    // ============================================================
    // Registered outputs. The rate settles one cycle after a write, which
    // keeps every output straight from a flip-flop.
    always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata                <= 8'h00;
            o_wake_rate_hz         <= 11'h000;
            o_rate_valid           <= 1'b0;
            o_soft_rate            <= 1'b0;
            o_manual_mode          <= 1'b0;
            o_activity_bias_nibble <= 4'h0;
            o_sampling_bias_nibble <= 4'h0;
            o_sampling_freq_pick   <= 5'h00;
            o_activity_freq_pick   <= 5'h00;
            o_sampling_clk_div     <= 16'h0000;
            o_activity_clk_div     <= 16'h0000;
            o_window_value         <= 8'h00;
        end else begin
            o_rdata        <= i_rd ? rdata_next : 8'h00;
            o_wake_rate_hz <= rate_next[10:0];
            o_rate_valid   <= rate_next[11];
            o_soft_rate    <= (rate_code == `WRC_CODE_SOFT);
            o_manual_mode  <= (shadow_select != `WRC_SEL_OFF);
            o_activity_bias_nibble <= shadow_reg[`WRC_SEL_BIAS][7:4];
            o_sampling_bias_nibble <= shadow_reg[`WRC_SEL_BIAS][3:0];
            o_sampling_freq_pick   <= shadow_reg[`WRC_SEL_SFPICK][4:0];
            o_activity_freq_pick   <= shadow_reg[`WRC_SEL_AFPICK][4:0];
            o_sampling_clk_div <= {shadow_reg[`WRC_SEL_SDIV_HI],
                                   shadow_reg[`WRC_SEL_SDIV_LO]};
            o_activity_clk_div <= {shadow_reg[`WRC_SEL_ADIV_HI],
                                   shadow_reg[`WRC_SEL_ADIV_LO]};
            o_window_value <= window_reg;
        end
    end

endmodule // wrc_top

/* File: wrc_top_props.sv */
// Port-level assertions for the wake rate register bank.
// Assumes it is bound onto wrc_top and sees only its ports.
`timescale 1ns/1ps
module wrc_top_props (
    // Clock, reset and register port
    input wire        i_core_clk,
    input wire        i_rst_b,
    input wire [7:0]  i_addr,
    input wire [7:0]  i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    // Observed outputs
    input wire [7:0]  o_rdata,
    input wire [10:0] o_wake_rate_hz,
    input wire        o_rate_valid,
    input wire        o_soft_rate,
    input wire        o_manual_mode
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // ======
    // Rate register write, then a quiet cycle so both output lags agree.
    sequence wr_rate_s;
        i_wr && i_addr == 8'h11 ##1 !i_wr;
    endsequence
    rd_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not zero outside read");
    rd_back_a: assert property (i_wr && i_addr == 8'h11 ##1 i_rd &&
        i_addr == 8'h11 |=> o_rdata == ($past(i_wdata, 2) & 8'h7F))
        else $error("rate register read back wrong");
    rd_unmap_a: assert property (i_rd && !(i_addr inside {8'h11, 8'h1C,
        8'h29}) |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    soft_flag_a: assert property (wr_rate_s |=> o_soft_rate ==
        (($past(i_wdata, 2) & 8'h0F) == 8'h0F)) else $error("soft flag");
    manual_mode_a: assert property (wr_rate_s |=> o_manual_mode ==
        (($past(i_wdata, 2) & 8'h70) != 8'h00)) else $error("manual mode");
    rate_stand_a: assert property (!i_wr [*2] |=> $stable(o_wake_rate_hz))
        else $error("rate changed with no write");
    invalid_zero_a: assert property (!o_rate_valid |->
        o_wake_rate_hz == 11'h000) else $error("undefined rate not zero");
    soft_value_a: assert property (o_soft_rate && o_rate_valid |->
        o_wake_rate_hz inside {11'h514, 11'h2EE, 11'h064})
        else $error("software rate value wrong");
endmodule // wrc_top_props

/* File: wake_rate_config_tb_top.sv */
// Self-checking bench for the wake rate register bank.
// Assumes wrc_top and wrc_top_props are compiled beside it.
`timescale 1ns/1ps
module wake_rate_config_tb_top;
    logic        i_core_clk = 1'b0;
    logic        i_rst_b    = 1'b0;
    logic        i_wr       = 1'b0;
    logic        i_rd       = 1'b0;
    logic [7:0]  i_addr     = 8'h00;
    logic [7:0]  i_wdata    = 8'h00;
    wire  [7:0]  o_rdata, o_window_value;
    wire  [10:0] o_wake_rate_hz;
    wire         o_rate_valid, o_soft_rate, o_manual_mode;
    wire  [3:0]  o_activity_bias_nibble, o_sampling_bias_nibble;
    wire  [4:0]  o_sampling_freq_pick, o_activity_freq_pick;
    wire  [15:0] o_sampling_clk_div, o_activity_clk_div;
    int          fail_count = 0;
    int          n_checks   = 0;
    int          cycles     = 0;
    logic [7:0]  modes [0:2] = '{8'h03, 8'h00, 8'h04};
    // Codes 0x05..0x0C, then code 0x0F in the last slot; zero is undefined.
    logic [10:0] tab [0:2][0:8] = '{
        '{11'h000, 11'h019, 11'h032, 11'h064, 11'h0BE, 11'h17C, 11'h2EE,
          11'h44C, 11'h514},
        '{11'h00E, 11'h01C, 11'h036, 11'h069, 11'h0D2, 11'h190, 11'h258,
          11'h000, 11'h2EE},
        '{11'h00E, 11'h01C, 11'h037, 11'h050, 11'h000, 11'h000, 11'h000,
          11'h000, 11'h064}};
    wrc_top wrc_top_inst (
        .i_core_clk             (i_core_clk),
        .i_rst_b                (i_rst_b),
        .i_addr                 (i_addr),
        .i_wdata                (i_wdata),
        .i_wr                   (i_wr),
        .i_rd                   (i_rd),
        .o_rdata                (o_rdata),
        .o_wake_rate_hz         (o_wake_rate_hz),
        .o_rate_valid           (o_rate_valid),
        .o_soft_rate            (o_soft_rate),
        .o_manual_mode          (o_manual_mode),
        .o_activity_bias_nibble (o_activity_bias_nibble),
        .o_sampling_bias_nibble (o_sampling_bias_nibble),
        .o_sampling_freq_pick   (o_sampling_freq_pick),
        .o_activity_freq_pick   (o_activity_freq_pick),
        .o_sampling_clk_div     (o_sampling_clk_div),
        .o_activity_clk_div     (o_activity_clk_div),
        .o_window_value         (o_window_value)
    );
    // ======
    // Bus cycles and comparison
    task automatic check(input logic [15:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s: %h vs %h", $time, what, got, exp);
        end
    endtask
    // The extra edge lets derived outputs settle after their one-cycle lag.
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        @(posedge i_core_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 check(o_rdata, exp, "read");
    endtask
    // ======
    // Scenarios
    task automatic t_table();
        logic [10:0] e;
        for (int m = 0; m < 3; m++) begin
            wr(8'h1C, modes[m]);
            for (int c = 0; c < 16; c++) begin
                wr(8'h11, 8'(c));
                e = (c >= 5 && c <= 12) ? tab[m][c-5] : 11'h000;
                if (c == 15) e = tab[m][8];
                check(o_wake_rate_hz, e, "rate");
                check(o_rate_valid, e != 11'h000, "valid");
                check(o_soft_rate, c == 15, "soft");
            end
        end
        wr(8'h1C, 8'h01);
        wr(8'h11, 8'h06);
        check(o_rate_valid, 1'b0, "bad mode");
    endtask
    task automatic t_shadow();
        for (int s = 1; s < 8; s++) begin
            wr(8'h11, {1'b0, 3'(s), 4'h6});
            wr(8'h29, 8'hF0 | 8'(s));
            rd(8'h29, ((s == 2 || s == 3) ? 8'h10 : 8'hF0) | 8'(s));
            check(o_manual_mode, 1'b1, "manual");
        end
        check({o_activity_bias_nibble, o_sampling_bias_nibble}, 8'hF1, "bias");
        check({o_sampling_freq_pick, o_activity_freq_pick}, 10'h253, "pick");
        check(o_sampling_clk_div, 16'hF5F4, "sdiv");
        check(o_activity_clk_div, 16'hF7F6, "adiv");
        wr(8'h11, 8'h06);
        wr(8'h29, 8'hAA);
        check(o_window_value, 8'hAA, "window");
        check(o_sampling_clk_div, 16'hF5F4, "shadow kept");
        rd(8'h29, 8'hAA);
    endtask
    task automatic t_reserved();
        wr(8'h11, 8'hFF);
        rd(8'h11, 8'h7F);
        wr(8'h55, 8'h3C);
        rd(8'h55, 8'h00);
        // Write then read with no gap, as the bus allows.
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= 8'h11;
        i_wdata <= 8'hA5;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 check(o_rdata, 8'h25, "back to back");
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ======
    // Clock, watchdog and main sequence
    initial forever #10 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("CHECK FAILED %0t run too long", $time);
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        rd(8'h11, 8'h00);
        rd(8'h1C, 8'h00);
        rd(8'h29, 8'h00);
        t_table();
        t_shadow();
        t_reserved();
        give_verdict();
    end
endmodule // wake_rate_config_tb_top
bind wrc_top wrc_top_props wrc_top_props_inst (
    .i_core_clk     (i_core_clk),
    .i_rst_b        (i_rst_b),
    .i_addr         (i_addr),
    .i_wdata        (i_wdata),
    .i_wr           (i_wr),
    .i_rd           (i_rd),
    .o_rdata        (o_rdata),
    .o_wake_rate_hz (o_wake_rate_hz),
    .o_rate_valid   (o_rate_valid),
    .o_soft_rate    (o_soft_rate),
    .o_manual_mode  (o_manual_mode)
);
